// file: rtl/bfc_consts.vh
`ifndef BFC_CONSTS_VH
`define BFC_CONSTS_VH

// adc sample width of phase and bus voltages
`define BFC_ADC_W        12
// loop filter coefficient width and fraction bits (q3.12)
`define BFC_COEF_W       16
`define BFC_COEF_FRAC    12
// loop filter output width
`define BFC_Y_W          32
// reset values
`define BFC_Y_RST        32'h00000000
`define BFC_R_RST        13'h0000
`define BFC_CNT_RST      8'h00
`define BFC_GATE_RST     3'h0
// fault counter width and the fallback limit used for a zero setting
`define BFC_CNT_W        8
`define BFC_TRIP_MIN     8'h01
`define BFC_CNT_ONE      8'h01

`endif

// file: rtl/bfc_pi_filter.v
`timescale 1ns/1ps
`include "bfc_consts.vh"

// recursive pi loop filter, one update per accepted sample
module bfc_pi_filter (
  input  wire                          clk_sys,
  input  wire                          rst_n,
  input  wire                          flush,
  input  wire                          sample_valid,
  input  wire [`BFC_ADC_W-1:0]         phase_volt,
  input  wire [`BFC_ADC_W-1:0]         bus_volt,
  input  wire signed [`BFC_COEF_W-1:0] coef_a0,
  input  wire signed [`BFC_COEF_W-1:0] coef_a1,
  output reg  signed [`BFC_Y_W-1:0]    filt_out_reg,
  output reg                           filt_valid_reg
);

  reg  signed [12:0] r_prev_reg;
  wire signed [12:0] r_now;
  wire signed [28:0] prod_now;
  wire signed [28:0] prod_prev;
  wire signed [29:0] prod_sum;
  wire signed [29:0] prod_scaled;
  wire signed [`BFC_Y_W-1:0] filt_out_next;

  // back-emf sample: phase voltage less half the bus voltage
  assign r_now = $signed({1'b0, phase_volt})
               - $signed({2'b00, bus_volt[`BFC_ADC_W-1:1]});

  // a0, a1 come from the bilinear mapping of (1+s*t2)/(s*t1) at period t
  assign prod_now    = coef_a0 * r_now;
  assign prod_prev   = coef_a1 * r_prev_reg;
  assign prod_sum    = {prod_now[28], prod_now} + {prod_prev[28], prod_prev};
  assign prod_scaled = prod_sum >>> `BFC_COEF_FRAC;
  // y(n) = y(n-1) + a0*r(n) + a1*r(n-1); no saturation, software bounds gains
  assign filt_out_next = filt_out_reg
                       + {{2{prod_scaled[29]}}, prod_scaled};

  // state update; flush restarts the loop after a drive shutdown
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filt_out_reg   <= `BFC_Y_RST;
      r_prev_reg     <= `BFC_R_RST;
      filt_valid_reg <= 1'b0;
    end else if (flush) begin
      filt_out_reg   <= `BFC_Y_RST;
      r_prev_reg     <= `BFC_R_RST;
      filt_valid_reg <= 1'b0;
    end else begin
      filt_valid_reg <= sample_valid;
      if (sample_valid) begin
        filt_out_reg <= filt_out_next;
        r_prev_reg   <= r_now;
      end
    end
  end

endmodule // bfc_pi_filter

// file: rtl/bfc_motor_guard.v
`timescale 1ns/1ps
`include "bfc_consts.vh"

// Function
// - any overcurrent stops motor drive outputs
// - overcurrent blanks outputs for current cycle only
// - resume next cycle once overcurrent clears
// - persistent overcurrent escalates to latched shutdown
// - comparator drives output disable directly
// - disable acts inside the present switching cycle
// - cut-off works with the clock stopped
// - pi filter (1+s*t2)/(s*t1)
// - bilinear discretisation at sampling period t
// - y(n)=y(n-1)+a0*r(n)+a1*r(n-1)
// - input is phase minus half bus voltage
module bfc_motor_guard (
  // clock and reset
  input  wire                          clk_sys,
  input  wire                          rst_n,
  // pwm demand from the timer logic, same clock
  input  wire [2:0]                    pwm_high_in,
  input  wire [2:0]                    pwm_low_in,
  input  wire                          pwm_cycle_start,
  input  wire                          drive_enable,
  // overcurrent pin, asynchronous to clk_sys
  input  wire                          oc_comp,
  // escalation setting and software clear of the latch
  input  wire [`BFC_CNT_W-1:0]         trip_limit,
  input  wire                          fault_clear,
  // back-emf samples and loop coefficients
  input  wire                          bemf_valid,
  input  wire [`BFC_ADC_W-1:0]         phase_volt,
  input  wire [`BFC_ADC_W-1:0]         bus_volt,
  input  wire signed [`BFC_COEF_W-1:0] coef_a0,
  input  wire signed [`BFC_COEF_W-1:0] coef_a1,
  // gate drive pins, active high
  output wire [2:0]                    gate_high,
  output wire [2:0]                    gate_low,
  // fault status
  output wire                          cycle_blank,
  output wire                          hard_shutdown,
  output wire                          fault_event,
  output wire [`BFC_CNT_W-1:0]         fault_cycles,
  // loop filter result
  output wire signed [`BFC_Y_W-1:0]    loop_out,
  output wire                          loop_valid
);

  // overcurrent pin synchroniser, for the clocked bookkeeping only
  reg                    oc_meta_reg;
  reg                    oc_sync_reg;
  reg                    oc_sync_d_reg;
  // per-cycle blank, consecutive-cycle counter and the shutdown latch
  reg                    oc_seen_reg;
  reg                    oc_seen_next;
  reg                    blank_reg;
  reg                    blank_next;
  reg  [`BFC_CNT_W-1:0]  cnt_reg;
  reg  [`BFC_CNT_W-1:0]  cnt_next;
  reg                    shut_reg;
  reg                    shut_next;
  // registered pwm demand from the timer logic
  reg  [2:0]             pwm_high_reg;
  reg  [2:0]             pwm_low_reg;
  reg                    event_reg;
  wire [`BFC_CNT_W-1:0]  limit_eff;
  wire                   drive_ok;
  wire                   oc_rise;

  // zero limit would never trip, so it is read as one cycle
  // the setting counts whole faulty cycles; the boundary that
  // judges the last of them raises the latch
  function [`BFC_CNT_W-1:0] eff_limit;
    input [`BFC_CNT_W-1:0] lim;
    begin
      if (lim == `BFC_CNT_RST)
        eff_limit = `BFC_TRIP_MIN;
      else
        eff_limit = lim;
    end
  endfunction

  assign limit_eff = eff_limit(trip_limit);

  // two-stage synchroniser; only the second stage is looked at
  // these flops feed the counter, the status and the cycle blank; the cut-off never
  // waits for them, so their delay costs nothing in the gate path
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_meta_reg   <= 1'b0;
      oc_sync_reg   <= 1'b0;
      oc_sync_d_reg <= 1'b0;
    end else begin
      oc_meta_reg   <= oc_comp;
      oc_sync_reg   <= oc_meta_reg;
      oc_sync_d_reg <= oc_sync_reg;
    end
  end

  assign oc_rise = oc_sync_reg & ~oc_sync_d_reg;

  // capture pwm demand so the pin drivers see clean, registered levels
  // one edge of latency; the gating term itself stays combinational
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_high_reg <= `BFC_GATE_RST;
      pwm_low_reg  <= `BFC_GATE_RST;
    end else begin
      pwm_high_reg <= pwm_high_in;
      pwm_low_reg  <= pwm_low_in;
    end
  end

  // one fault, counted from the pin going high:
  //   at once: gates off through drive_ok, no clock involved
  //   edge 1: first synchroniser stage takes the level
  //   edge 2: second stage high, the bookkeeping sees it
  //   edge 3: blank set and fault_event pulses
  //   next cycle start: the cycle is judged faulty, count steps
  //   count at the limit: shutdown latches, filter is flushed
  // a fault that ends mid-cycle keeps the blank to the cycle end,
  // so a chattering comparator cannot chop a pulse into slivers
  // only back-to-back faulty cycles add up; one clean cycle in
  // between brings the count back to zero
  // a spike shorter than a clock may be missed by the flops: it
  // cuts the gates for its own length only and is not counted
  // per-cycle fault bookkeeping and escalation
  always @* begin
    oc_seen_next = oc_seen_reg;
    blank_next   = blank_reg;
    cnt_next     = cnt_reg;
    shut_next    = shut_reg;
    if (pwm_cycle_start) begin
      // judge the cycle just ended, then start the new one clean
      if (oc_seen_reg) begin
        if (cnt_reg >= limit_eff - `BFC_CNT_ONE) begin
          shut_next = 1'b1;
          cnt_next  = limit_eff;
        end else begin
          cnt_next  = cnt_reg + `BFC_CNT_ONE;
        end
      end else begin
        cnt_next = `BFC_CNT_RST;
      end
      // blank clears at the boundary unless the fault is still there
      oc_seen_next = oc_sync_reg;
      blank_next   = oc_sync_reg;
    end else if (oc_sync_reg) begin
      // hold outputs off for the remainder of this cycle
      oc_seen_next = 1'b1;
      blank_next   = 1'b1;
    end
    // clear only ends the latch if no new trip lands in the same cycle
    // clearing with the fault still present restarts the count at zero,
    // so the latch comes back after another full run of faulty cycles
    if (fault_clear && !(shut_next && !shut_reg)) begin
      shut_next = 1'b0;
      cnt_next  = `BFC_CNT_RST;
    end
  end

  // fault state registers
  // async reset: gates off and counts clear with no clock edge needed
  // the latch is not kept across reset; reset is a legal way out
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oc_seen_reg <= 1'b0;
      blank_reg   <= 1'b0;
      cnt_reg     <= `BFC_CNT_RST;
      shut_reg    <= 1'b0;
      event_reg   <= 1'b0;
    end else begin
      oc_seen_reg <= oc_seen_next;
      blank_reg   <= blank_next;
      cnt_reg     <= cnt_next;
      shut_reg    <= shut_next;
      event_reg   <= oc_rise;
    end
  end

  // any one term holds all six gates off:
  //   raw comparator, shutdown latch, cycle blank, firmware enable
  // the raw term covers the edges before the blank is set; the
  // blank then keeps gates off after the pin drops mid-cycle
  // limitation: a noisy pin glitches the gates directly
  // the raw comparator sits in the gating term with no flop in between:
  // it cuts the gates at once and still works if clk_sys stops, at the
  // cost of a combinational path from a pin to the gate outputs
  assign drive_ok = drive_enable & ~oc_comp & ~blank_reg
                  & ~shut_reg;

  // gate outputs; all six go inactive (low) on any fault
  assign gate_high = pwm_high_reg & {3{drive_ok}};
  assign gate_low  = pwm_low_reg & {3{drive_ok}};

  // status towards firmware
  // all status comes from flops, so firmware reads stay glitch free;
  // fault_cycles drops to zero after one clean cycle, even latched
  assign cycle_blank   = blank_reg;
  assign hard_shutdown = shut_reg;
  assign fault_event   = event_reg;
  assign fault_cycles  = cnt_reg;

  // flushing drops the integrator state, so a restart after a clear
  // does not begin from a stale, wound-up phase error; the trade is
  // a short settling time of the loop after every restart
  // back-emf pll loop filter; restarted while the drive is shut down
  bfc_pi_filter u_pi_filter (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .flush          (shut_reg),
    .sample_valid   (bemf_valid),
    .phase_volt     (phase_volt),
    .bus_volt       (bus_volt),
    .coef_a0        (coef_a0),
    .coef_a1        (coef_a1),
    .filt_out_reg   (loop_out),
    .filt_valid_reg (loop_valid)
  );

endmodule // bfc_motor_guard

// file: test/bfc_drive_model.sv
`timescale 1ns/1ps
// far side: gate drivers plus the overcurrent sense comparator
module bfc_drive_model (
  input  wire [2:0] gate_high,
  input  wire [2:0] gate_low,
  input  wire       overload,
  output wire       oc_comp
);
  // comparator follows the load, not the gates: avoids a cut-off loop
  assign #3 oc_comp = overload & ((|gate_high) | ~(|gate_low) | 1'b1);
endmodule // bfc_drive_model

// file: test/bfc_guard_sva.sv
`timescale 1ns/1ps
// cut-off, shutdown latch and filter strobe checks
module bfc_guard_sva (
  input wire       clk_sys,
  input wire       rst_n,
  input wire [2:0] pwm_high_in,
  input wire       pwm_cycle_start,
  input wire       drive_enable,
  input wire       oc_comp,
  input wire [7:0] trip_limit,
  input wire       fault_clear,
  input wire       bemf_valid,
  input wire [2:0] gate_high,
  input wire [2:0] gate_low,
  input wire       cycle_blank,
  input wire       hard_shutdown,
  input wire       fault_event,
  input wire [7:0] fault_cycles,
  input wire       loop_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [5:0] gates = {gate_high, gate_low};
  wire [7:0] lim = (trip_limit == 8'h00) ? 8'h01 : trip_limit;
  // demand may pass only with nothing holding the gates off
  wire quiet = !oc_comp && !cycle_blank && !hard_shutdown && drive_enable;
  oc_cut_a: assert property (oc_comp |-> gates == 6'h00)
    else $error("gates on in overcurrent");
  gate_off_a: assert property (
    cycle_blank || hard_shutdown || !drive_enable |-> gates == 6'h00)
    else $error("gates on while blanked");
  pwm_pass_a: assert property (
    quiet && $past(quiet) |-> gate_high == $past(pwm_high_in))
    else $error("demand not passed");
  shut_hold_a: assert property (
    hard_shutdown && !fault_clear |=> hard_shutdown)
    else $error("shutdown dropped");
  shut_clear_a: assert property (
    hard_shutdown && fault_clear && !pwm_cycle_start |=> !hard_shutdown)
    else $error("clear ignored");
  trip_count_a: assert property (
    $rose(hard_shutdown) |-> fault_cycles == lim && $past(pwm_cycle_start))
    else $error("trip count wrong");
  blank_end_a: assert property (pwm_cycle_start && !hard_shutdown &&
    !oc_comp && !$past(oc_comp) && !$past(oc_comp, 2) && !$past(oc_comp, 3)
    |=> !cycle_blank) else $error("blanking not released");
  filt_strobe_a: assert property (
    bemf_valid && !hard_shutdown && !pwm_cycle_start |=> loop_valid)
    else $error("no filter update");
  event_blank_a: assert property (
    fault_event |-> cycle_blank && !$past(fault_event))
    else $error("fault event without blank");
  cover property (fault_event);
  cover property ($rose(cycle_blank));
  cover property ($rose(hard_shutdown));
  cover property (loop_valid ##1 !loop_valid);
endmodule // bfc_guard_sva

bind bfc_motor_guard bfc_guard_sva chk (
  .clk_sys         (clk_sys),
  .rst_n           (rst_n),
  .pwm_high_in     (pwm_high_in),
  .pwm_cycle_start (pwm_cycle_start),
  .drive_enable    (drive_enable),
  .oc_comp         (oc_comp),
  .trip_limit      (trip_limit),
  .fault_clear     (fault_clear),
  .bemf_valid      (bemf_valid),
  .gate_high       (gate_high),
  .gate_low        (gate_low),
  .cycle_blank     (cycle_blank),
  .hard_shutdown   (hard_shutdown),
  .fault_event     (fault_event),
  .fault_cycles    (fault_cycles),
  .loop_valid      (loop_valid)
);

// file: test/bfc_motor_guard_tb.sv
`timescale 1ns/1ps
module bfc_motor_guard_tb;
  reg                clk_sys = 1'b0, clk_run = 1'b1, rst_n = 1'b0;
  reg  [2:0]         pwm_high_in = 3'h0, pwm_low_in = 3'h0;
  reg                pwm_cycle_start = 1'b0, drive_enable = 1'b1;
  reg                overload = 1'b0, fault_clear = 1'b0;
  reg                bemf_valid = 1'b0, pwm_run = 1'b0;
  reg  [7:0]         trip_limit = 8'h08;
  reg  [11:0]        phase_volt = 12'h000, bus_volt = 12'h000;
  reg  signed [15:0] coef_a0 = 16'sh0000, coef_a1 = 16'sh0000;
  wire [2:0]         gate_high, gate_low;
  wire               oc_comp, cycle_blank, hard_shutdown;
  wire               fault_event, loop_valid;
  wire [7:0]         fault_cycles;
  wire signed [31:0] loop_out;
  reg  [15:0]        rnd = 16'hfd2d;
  reg  [5:0]         pq = 6'h00;
  reg  [3:0]         ph = 4'h0;
  reg  signed [31:0] ey = 32'sh0;
  reg  signed [12:0] rp = 13'sh0, r;
  integer            bad_count = 0, n_compared = 0, i;
  bfc_drive_model PART (.gate_high(gate_high), .gate_low(gate_low),
    .overload(overload), .oc_comp(oc_comp));
  bfc_motor_guard DUT (
    .clk_sys         (clk_sys),
    .rst_n           (rst_n),
    .pwm_high_in     (pwm_high_in),
    .pwm_low_in      (pwm_low_in),
    .pwm_cycle_start (pwm_cycle_start),
    .drive_enable    (drive_enable),
    .oc_comp         (oc_comp),
    .trip_limit      (trip_limit),
    .fault_clear     (fault_clear),
    .bemf_valid      (bemf_valid),
    .phase_volt      (phase_volt),
    .bus_volt        (bus_volt),
    .coef_a0         (coef_a0),
    .coef_a1         (coef_a1),
    .gate_high       (gate_high),
    .gate_low        (gate_low),
    .cycle_blank     (cycle_blank),
    .hard_shutdown   (hard_shutdown),
    .fault_event     (fault_event),
    .fault_cycles    (fault_cycles),
    .loop_out        (loop_out),
    .loop_valid      (loop_valid)
  );
  function [15:0] nx(input [15:0] x);
    nx = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // expected output, from the bench's own filter history
  function signed [31:0] fy(input signed [12:0] rn, input signed [12:0] rl);
    reg signed [29:0] s;
    begin
      s = coef_a0 * rn + coef_a1 * rl;
      fy = ey + (s >>> 12);
    end
  endfunction
  task chk_loop(input [31:0] g, input [31:0] e);
    begin
      n_compared = n_compared + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task chk_bits(input [7:0] g, input [7:0] e);
    chk_loop({24'h0, g}, {24'h0, e});
  endtask
  task summarize;
    begin
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  always #12.5 clk_sys = clk_run ? ~clk_sys : 1'b0;
  // fresh demand every clock, cycle start every 16 clocks
  always @(posedge clk_sys) begin
    rnd <= nx(rnd);
    ph <= ph + 4'h1;
    pwm_cycle_start <= (ph == 4'hf);
    pq <= {pwm_high_in, pwm_low_in};
    if (pwm_run) begin
      {pwm_high_in, pwm_low_in} <= rnd[5:0];
    end
  end
  // first sample of each batch is the extreme corner
  task filt(input integer n);
    for (i = 0; i < n; i = i + 1) begin
      @(posedge clk_sys);
      phase_volt <= (i == 0) ? 12'h000 : rnd[11:0];
      bus_volt <= (i == 0) ? 12'hfff : {rnd[2:0], rnd[15:7]};
      coef_a0 <= (i == 0) ? 16'sh7fff : rnd;
      coef_a1 <= (i == 0) ? 16'sh8000 : {rnd[7:0], rnd[15:8]};
      bemf_valid <= 1'b1;
      @(posedge clk_sys);
      bemf_valid <= 1'b0;
      #1;
      r = $signed({1'b0, phase_volt}) - $signed({2'b00, bus_volt[11:1]});
      ey = fy(r, rp);
      rp = r;
      chk_loop(loop_out, ey);
      chk_bits(loop_valid, 1'b1);
    end
  endtask
  task trip(input [7:0] lim);
    begin
      @(posedge clk_sys);
      trip_limit <= lim;
      overload <= 1'b1;
      for (i = 0; i < 300 && hard_shutdown !== 1'b1; i = i + 1) begin
        @(posedge clk_sys);
        #1;
      end
      chk_bits(fault_cycles, (lim == 8'h00) ? 8'h01 : lim);
      @(posedge clk_sys);
      overload <= 1'b0;
      repeat (40) @(posedge clk_sys);
      #1;
      chk_bits({hard_shutdown, gate_high, gate_low}, 8'h40);
      @(posedge clk_sys);
      fault_clear <= 1'b1;
      @(posedge clk_sys);
      fault_clear <= 1'b0;
      #1;
      chk_bits({hard_shutdown, fault_cycles[6:0]}, 8'h00);
      ey = 32'sh0;
      rp = 13'sh0;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    pwm_run <= 1'b1;
    filt(24);
    @(posedge clk_sys);
    overload <= 1'b1;
    #5 chk_bits({2'b00, gate_high, gate_low}, 8'h00);
    // third edge after the pin: blank set and event pulse up
    repeat (3) @(posedge clk_sys);
    #1 chk_bits({fault_event, cycle_blank, hard_shutdown}, 8'h06);
    @(posedge clk_sys);
    #1 chk_bits({fault_event, cycle_blank, hard_shutdown}, 8'h02);
    @(posedge clk_sys);
    overload <= 1'b0;
    drive_enable <= 1'b0;
    @(posedge clk_sys);
    drive_enable <= 1'b1;
    repeat (36) @(posedge clk_sys);
    #1 chk_bits({cycle_blank, gate_high, gate_low}, {2'b00, pq});
    trip(8'h03);
    trip(8'h00);
    filt(6);
    // hold a known demand, then stop the clock and fault the load
    pwm_run <= 1'b0;
    @(posedge clk_sys);
    {pwm_high_in, pwm_low_in} <= 6'h2a;
    repeat (2) @(posedge clk_sys);
    #1 chk_bits({2'b00, gate_high, gate_low}, 8'h2a);
    clk_run = 1'b0;
    #100 overload = 1'b1;
    #10 chk_bits({2'b00, gate_high, gate_low}, 8'h00);
    overload = 1'b0;
    #100 clk_run = 1'b1;
    summarize;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    summarize;
  end
endmodule // bfc_motor_guard_tb
